// >>> hdl/mbpm_slave.sv
// modbus rtu slave frame engine with parameter and status map
//
// Behaviour
// - node address register holds 1 through 247
// - bit rate code 0..7 selects 1200 up to 115200 baud
// - parity code 0 none, 1 even, 2 odd
// - signed pv offset kept between lower and upper range limits
// - two registers hold display range low and high limits
// - writes capture applied input as calibration start or end point
// - writing 1 to restore register reinstates factory calibration
// - protection level accepts only levels one to three
// - status word one: alarms in bits 0,1, hardware values in 8,9
// - status word two: initial blocks in bits 5,6, unit in bit 9
// - status word three bits 0..2: very low, negative, very high
// - status word three bits 3..6: further conversion faults
// - coil 0 is output one, coil 1 is output two
// - coil writes change an output only when it has no alarm
// - frame with bad crc is dropped without reply
// - exception reply carries function code plus 80 hex
// - exception codes 01 function, 02 register, 03 quantity
// - out of range write stores and echoes the nearest limit
// - broadcast reads are ignored; broadcast only for writes
// - valid requests perform the requested reads and writes
// - temperature unit 0 celsius, 1 fahrenheit in status bit
`timescale 1ns/1ns
`default_nettype none
module mbpm_slave
    import mbpm_pkg::*;
#(
    parameter int QMAX = 8
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_end,
    input  wire logic        i_tx_ready,
    input  wire logic [15:0] i_range_lower_limit,
    input  wire logic [15:0] i_range_upper_limit,
    input  wire logic [1:0]  i_alarm_active,
    input  wire logic [1:0]  i_hw_detect,
    input  wire logic [1:0]  i_alarm_init_block,
    input  wire logic        i_temp_unit,
    input  wire logic [6:0]  i_conv_fault,
    input  wire logic [1:0]  i_output_alarm_assigned,
    output logic      [7:0]  o_tx_data,
    output logic             o_tx_valid,
    output logic             o_tx_last,
    output logic      [7:0]  o_node_address,
    output logic      [2:0]  o_bit_rate_select,
    output logic      [1:0]  o_parity_select,
    output logic      [15:0] o_pv_offset,
    output logic      [15:0] o_display_range_low,
    output logic      [15:0] o_display_range_high,
    output logic      [1:0]  o_protection_level,
    output logic             o_cal_start_pulse,
    output logic             o_cal_end_pulse,
    output logic             o_factory_restore_pulse,
    output logic      [1:0]  o_output
);

    // ====================================================================
    // state
    typedef struct packed {
        mbpm_state_t st;
        logic [47:0] rx_buf;
        logic [3:0]  rx_cnt;
        logic [15:0] rx_crc;
        logic [15:0] tx_crc;
        logic [7:0]  resp_fc;
        logic [7:0]  resp_code;
        logic [15:0] resp_addr;
        logic [15:0] resp_qty;
        logic [7:0]  idx;
        logic [7:0]  len;
        logic [7:0]  tx_data;
        logic        tx_valid;
        logic        tx_last;
        logic [15:0] pv_offset;
        logic [15:0] range_low;
        logic [15:0] range_high;
        logic [15:0] node_address;
        logic [15:0] bit_rate_select;
        logic [15:0] parity_select;
        logic [15:0] cal_start;
        logic [15:0] cal_end;
        logic [15:0] restore;
        logic [15:0] protection_level;
        logic [7:0]  act_node;
        logic [2:0]  act_rate;
        logic [1:0]  act_par;
        logic [1:0]  coil;
        logic        cal_start_pulse;
        logic        cal_end_pulse;
        logic        restore_pulse;
    } mbpm_regs_t;

    mbpm_regs_t r;
    mbpm_regs_t next_r;

    // ====================================================================
    // request fields and decode
    logic [7:0]  rq_node;
    logic [7:0]  rq_fc;
    logic [15:0] rq_addr;
    logic [15:0] rq_val;
    logic        frame_ok;
    logic        dec;
    logic        accept;
    logic        reply;
    logic        is_read;
    logic [7:0]  exc;

    assign rq_node  = r.rx_buf[7:0];
    assign rq_fc    = r.rx_buf[15:8];
    assign rq_addr  = {r.rx_buf[23:16], r.rx_buf[31:24]};
    assign rq_val   = {r.rx_buf[39:32], r.rx_buf[47:40]};
    // crc over the whole frame, its own crc included, leaves zero
    assign frame_ok = (r.rx_crc == 16'h0000) && (r.rx_cnt == FRAME_LEN);
    assign dec      = (r.st == MBPM_IDLE) && i_rx_end;
    assign accept   = dec && frame_ok
                    && (rq_node == r.act_node || rq_node == NODE_BCAST);
    assign is_read  = (rq_fc == FC_READ_COILS) || (rq_fc == FC_READ_HOLD);
    // broadcasts never get a reply, not even an exception
    assign reply    = accept && (rq_node != NODE_BCAST);

    // crc-16 with reflected polynomial, one byte at a time
    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [7:0]  b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++)
        begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction : crc_upd

    function automatic logic writable(input logic [15:0] a);
        return a == REG_PV_OFFSET || a == REG_RANGE_LOW
            || a == REG_RANGE_HIGH || a == REG_NODE || a == REG_RATE
            || a == REG_PARITY || a == REG_CAL_START
            || a == REG_CAL_END || a == REG_RESTORE || a == REG_PROT;
    endfunction : writable

    // reserved gaps fall through and count as bad register numbers
    function automatic logic readable(input logic [15:0] a);
        return writable(a) || a == REG_STATUS1 || a == REG_STATUS2
            || a == REG_STATUS3;
    endfunction : readable

    // read value of one register; reserved status bits stay zero
    function automatic logic [15:0] reg_read(input logic [15:0] a);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            REG_PV_OFFSET:  v = r.pv_offset;
            REG_RANGE_LOW:  v = r.range_low;
            REG_RANGE_HIGH: v = r.range_high;
            REG_NODE:       v = r.node_address;
            REG_RATE:       v = r.bit_rate_select;
            REG_PARITY:     v = r.parity_select;
            REG_CAL_START:  v = r.cal_start;
            REG_CAL_END:    v = r.cal_end;
            REG_RESTORE:    v = r.restore;
            REG_PROT:       v = r.protection_level;
            REG_STATUS1:    v = {6'h00, i_hw_detect,
                                 6'h00, i_alarm_active};
            REG_STATUS2:    v = {6'h00, i_temp_unit, 2'h0,
                                 i_alarm_init_block, 5'h00};
            REG_STATUS3:    v = {9'h000, i_conv_fault};
            default:        v = 16'h0000;
        endcase
        return v;
    endfunction : reg_read

    // nearest limit for an out of range value
    function automatic logic [15:0] clamp(input logic [15:0] a,
                                          input logic [15:0] v);
        logic [15:0] c;
        c = v;
        unique case (a)
            REG_PV_OFFSET:
            begin
                if ($signed(v) < $signed(i_range_lower_limit))
                    c = i_range_lower_limit;
                else if ($signed(v) > $signed(i_range_upper_limit))
                    c = i_range_upper_limit;
            end
            REG_NODE:
                c = (v < NODE_MIN) ? NODE_MIN
                  : (v > NODE_MAX) ? NODE_MAX : v;
            REG_RATE:    c = (v > RATE_MAX) ? RATE_MAX : v;
            REG_PARITY:  c = (v > PARITY_MAX) ? PARITY_MAX : v;
            REG_RESTORE: c = (v > RESTORE_MAX) ? RESTORE_MAX : v;
            REG_PROT:
                c = (v < PROT_MIN) ? PROT_MIN
                  : (v > PROT_MAX) ? PROT_MAX : v;
            default:     c = v;
        endcase
        return c;
    endfunction : clamp

    // ====================================================================
    // request checks, first failing check picks the code
    always_comb
    begin
        exc = EXC_NONE;
        unique case (rq_fc)
            FC_READ_HOLD:
            begin
                if (rq_val == 16'h0000 || rq_val > 16'(QMAX))
                    exc = EXC_QTY;
                else
                begin
                    for (int k = 0; k < QMAX; k++)
                    begin
                        if (16'(k) < rq_val
                            && !readable(rq_addr + 16'(k)))
                            exc = EXC_REG;
                    end
                end
            end
            FC_READ_COILS:
            begin
                if (rq_addr >= NUM_COILS)
                    exc = EXC_REG;
                else if (rq_val == 16'h0000
                         || rq_addr + rq_val > NUM_COILS)
                    exc = EXC_QTY;
            end
            FC_WRITE_COIL:
            begin
                if (rq_addr >= NUM_COILS)
                    exc = EXC_REG;
                else if (rq_val != COIL_ON && rq_val != COIL_OFF)
                    exc = EXC_QTY;
            end
            FC_WRITE_REG:
                exc = writable(rq_addr) ? EXC_NONE : EXC_REG;
            default:
                exc = EXC_FUNC;
        endcase
    end

    // reply byte at position i, crc bytes excluded
    function automatic logic [7:0] resp_byte(input logic [7:0] i);
        logic [7:0]  k;
        logic [15:0] w;
        logic [7:0]  b;
        k = i - 8'h03;
        w = reg_read(r.resp_addr + {9'h000, k[7:1]});
        b = 8'h00;
        if (i == 8'h00)
            b = r.act_node;
        else if (i == 8'h01)
            b = (r.resp_code != EXC_NONE)
              ? (r.resp_fc | EXC_FLAG) : r.resp_fc;
        else if (r.resp_code != EXC_NONE)
            b = r.resp_code;
        else if (r.resp_fc == FC_READ_HOLD)
            b = (i == 8'h02) ? {r.resp_qty[6:0], 1'b0}
              : (k[0] ? w[7:0] : w[15:8]);
        else if (r.resp_fc == FC_READ_COILS)
            b = (i == 8'h02) ? 8'h01
              : ({6'h00, r.coil} >> r.resp_addr[0])
                & (r.resp_qty[1] ? 8'h03 : 8'h01);
        else
            b = (i == 8'h02) ? r.resp_addr[15:8]
              : (i == 8'h03) ? r.resp_addr[7:0]
              : (i == 8'h04) ? r.resp_qty[15:8] : r.resp_qty[7:0];
        return b;
    endfunction : resp_byte

    // ====================================================================
    // next state
    always_comb
    begin
        logic [15:0] wv;
        logic        apply;
        wv    = clamp(rq_addr, rq_val);
        apply = 1'b0;
        next_r = r;
        next_r.cal_start_pulse = 1'b0;
        next_r.cal_end_pulse   = 1'b0;
        next_r.restore_pulse   = 1'b0;

        // receive: bytes are ignored while a reply is going out
        if (r.st == MBPM_IDLE && i_rx_valid)
        begin
            if (r.rx_cnt < 4'h6)
                next_r.rx_buf[8*r.rx_cnt +: 8] = i_rx_data;
            if (r.rx_cnt != 4'hf)
                next_r.rx_cnt = r.rx_cnt + 4'h1;
            next_r.rx_crc = crc_upd(r.rx_crc, i_rx_data);
        end

        // frame end: bad crc or foreign address just resets reception
        if (dec)
        begin
            next_r.rx_cnt = 4'h0;
            next_r.rx_crc = CRC_INIT;
        end

        // execute writes of an accepted, error free request
        if (accept && exc == EXC_NONE && rq_fc == FC_WRITE_REG)
        begin
            unique case (rq_addr)
                REG_PV_OFFSET:  next_r.pv_offset = wv;
                REG_RANGE_LOW:  next_r.range_low = wv;
                REG_RANGE_HIGH: next_r.range_high = wv;
                REG_NODE:       next_r.node_address = wv;
                REG_RATE:       next_r.bit_rate_select = wv;
                REG_PARITY:     next_r.parity_select = wv;
                REG_CAL_START:
                begin
                    next_r.cal_start = wv;
                    next_r.cal_start_pulse = 1'b1;
                end
                REG_CAL_END:
                begin
                    next_r.cal_end = wv;
                    next_r.cal_end_pulse = 1'b1;
                end
                REG_RESTORE:
                begin
                    next_r.restore = wv;
                    next_r.restore_pulse = wv[0];
                end
                REG_PROT:       next_r.protection_level = wv;
                default:        next_r.pv_offset = r.pv_offset;
            endcase
        end
        if (accept && exc == EXC_NONE && rq_fc == FC_WRITE_COIL
            && !i_output_alarm_assigned[rq_addr[0]])
            next_r.coil[rq_addr[0]] = (rq_val == COIL_ON);

        // start a reply; a broadcast write applies settings at once
        if (reply)
        begin
            next_r.st        = MBPM_SEND;
            next_r.idx       = 8'h00;
            next_r.tx_crc    = CRC_INIT;
            next_r.resp_fc   = rq_fc;
            next_r.resp_code = exc;
            next_r.resp_addr = rq_addr;
            next_r.resp_qty  = (rq_fc == FC_WRITE_REG) ? wv : rq_val;
            next_r.len       = (exc != EXC_NONE) ? 8'h03
                             : (rq_fc == FC_READ_HOLD)
                               ? 8'h03 + {rq_val[6:0], 1'b0}
                             : (rq_fc == FC_READ_COILS) ? 8'h04 : 8'h06;
        end
        else if (accept && !is_read)
            apply = 1'b1;

        // transmit: a byte leaves on valid and ready
        if (r.tx_valid && i_tx_ready)
        begin
            next_r.tx_valid = 1'b0;
            if (r.tx_last)
            begin
                next_r.tx_last = 1'b0;
                next_r.st      = MBPM_IDLE;
                apply          = 1'b1;
            end
        end
        if (r.st == MBPM_SEND && next_r.st == MBPM_SEND
            && !next_r.tx_valid)
        begin
            next_r.tx_valid = 1'b1;
            next_r.idx      = r.idx + 8'h01;
            if (r.idx < r.len)
            begin
                next_r.tx_data = resp_byte(r.idx);
                next_r.tx_crc  = crc_upd(r.tx_crc, next_r.tx_data);
            end
            else if (r.idx == r.len)
                next_r.tx_data = r.tx_crc[7:0];
            else
            begin
                next_r.tx_data = r.tx_crc[15:8];
                next_r.tx_last = 1'b1;
            end
        end

        // new link settings take effect only here
        if (apply)
        begin
            next_r.act_node = next_r.node_address[7:0];
            next_r.act_rate = next_r.bit_rate_select[2:0];
            next_r.act_par  = next_r.parity_select[1:0];
        end
    end

    // ====================================================================
    // state register
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            r <= '0;
            r.st               <= MBPM_IDLE;
            r.rx_crc           <= CRC_INIT;
            r.tx_crc           <= CRC_INIT;
            r.node_address     <= RST_NODE;
            r.bit_rate_select  <= RST_RATE;
            r.parity_select    <= RST_ZERO;
            r.protection_level <= RST_PROT;
            r.act_node         <= RST_NODE[7:0];
            r.act_rate         <= RST_RATE[2:0];
            r.act_par          <= RST_ZERO[1:0];
        end
        else
            r <= next_r;
    end

    // outputs straight from the state flops
    assign o_tx_data               = r.tx_data;
    assign o_tx_valid              = r.tx_valid;
    assign o_tx_last               = r.tx_last;
    assign o_node_address          = r.act_node;
    assign o_bit_rate_select       = r.act_rate;
    assign o_parity_select         = r.act_par;
    assign o_pv_offset             = r.pv_offset;
    assign o_display_range_low     = r.range_low;
    assign o_display_range_high    = r.range_high;
    assign o_protection_level      = r.protection_level[1:0];
    assign o_cal_start_pulse       = r.cal_start_pulse;
    assign o_cal_end_pulse         = r.cal_end_pulse;
    assign o_factory_restore_pulse = r.restore_pulse;
    assign o_output                = r.coil;

    // ====================================================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_bad_frame;
        dec && !frame_ok;
    endsequence
    sequence s_bcast_read;
        dec && frame_ok && rq_node == NODE_BCAST && is_read;
    endsequence
    sequence s_send_done;
        o_tx_valid && o_tx_last && i_tx_ready;
    endsequence

    AST_CRC_DROP: assert property (
        s_bad_frame |=> r.st == MBPM_IDLE && !o_tx_valid)
        else $error("bad frame was answered");
    AST_BCAST_QUIET: assert property (
        s_bcast_read |=> r.st == MBPM_IDLE ##1 !o_tx_valid)
        else $error("broadcast read was answered");
    AST_EXC_FC: assert property (
        (o_tx_valid && r.idx == 8'h02 && r.resp_code != EXC_NONE)
        |-> o_tx_data == (r.resp_fc | EXC_FLAG))
        else $error("exception function field wrong");
    AST_EXC_CODE: assert property (
        (reply && exc == EXC_FUNC) |=> r.resp_code == EXC_FUNC
        && r.len == 8'h03)
        else $error("unsupported function not flagged");
    AST_NODE_RANGE: assert property (
        r.node_address >= NODE_MIN && r.node_address <= NODE_MAX)
        else $error("node address out of range");
    AST_RATE_RANGE: assert property (
        r.bit_rate_select <= RATE_MAX && r.parity_select <= PARITY_MAX)
        else $error("rate or parity code out of range");
    AST_PROT_RANGE: assert property (
        r.protection_level >= PROT_MIN && r.protection_level <= PROT_MAX)
        else $error("protection level out of range");
    AST_CLAMP: assert property (
        (accept && exc == EXC_NONE && rq_fc == FC_WRITE_REG
         && rq_addr == REG_NODE && rq_val > NODE_MAX)
        |=> r.node_address == NODE_MAX)
        else $error("node address write not clamped");
    AST_COIL_LOCK: assert property (
        i_output_alarm_assigned[0] |=> $stable(o_output[0]))
        else $error("alarm output changed by coil write");
    // the bench assigns an alarm to output two, so this one is exercised
    AST_COIL_LOCK1: assert property (
        i_output_alarm_assigned[1] |=> $stable(o_output[1]))
        else $error("alarm output two changed by coil write");
    AST_LATE_APPLY: assert property (
        !$stable(o_bit_rate_select)
        |-> $past(r.st == MBPM_IDLE) || $past(o_tx_valid && o_tx_last
                                              && i_tx_ready))
        else $error("bit rate applied before reply end");
    AST_SEND_END: assert property (
        s_send_done |=> r.st == MBPM_IDLE && o_node_address
        == r.node_address[7:0])
        else $error("settings not applied at reply end");

endmodule : mbpm_slave
`default_nettype wire

// >>> common/mbpm_pkg.sv
// constants and types for the modbus parameter and status map
package mbpm_pkg;

    // ====================================================================
    // holding register offsets
    localparam logic [15:0] REG_PV_OFFSET   = 16'h0038;
    localparam logic [15:0] REG_RANGE_LOW   = 16'h0039;
    localparam logic [15:0] REG_RANGE_HIGH  = 16'h003a;
    localparam logic [15:0] REG_NODE        = 16'h0043;
    localparam logic [15:0] REG_RATE        = 16'h0044;
    localparam logic [15:0] REG_PARITY      = 16'h0045;
    localparam logic [15:0] REG_CAL_START   = 16'h0050;
    localparam logic [15:0] REG_CAL_END     = 16'h0051;
    localparam logic [15:0] REG_RESTORE     = 16'h0052;
    localparam logic [15:0] REG_PROT        = 16'h0054;
    localparam logic [15:0] REG_STATUS1     = 16'h0064;
    localparam logic [15:0] REG_STATUS2     = 16'h0065;
    localparam logic [15:0] REG_STATUS3     = 16'h0066;

    // ====================================================================
    // function and exception codes
    localparam logic [7:0]  FC_READ_COILS   = 8'h01;
    localparam logic [7:0]  FC_READ_HOLD    = 8'h03;
    localparam logic [7:0]  FC_WRITE_COIL   = 8'h05;
    localparam logic [7:0]  FC_WRITE_REG    = 8'h06;
    localparam logic [7:0]  EXC_FLAG        = 8'h80;
    localparam logic [7:0]  EXC_NONE        = 8'h00;
    localparam logic [7:0]  EXC_FUNC        = 8'h01;
    localparam logic [7:0]  EXC_REG         = 8'h02;
    localparam logic [7:0]  EXC_QTY         = 8'h03;
    localparam logic [7:0]  NODE_BCAST      = 8'h00;

    // ====================================================================
    // limits, coil values, crc, frame size
    localparam logic [15:0] NODE_MIN        = 16'h0001;
    localparam logic [15:0] NODE_MAX        = 16'h00f7;
    localparam logic [15:0] RATE_MAX        = 16'h0007;
    localparam logic [15:0] PARITY_MAX      = 16'h0002;
    localparam logic [15:0] RESTORE_MAX     = 16'h0001;
    localparam logic [15:0] PROT_MIN        = 16'h0001;
    localparam logic [15:0] PROT_MAX        = 16'h0003;
    localparam logic [15:0] COIL_ON         = 16'hff00;
    localparam logic [15:0] COIL_OFF        = 16'h0000;
    localparam logic [15:0] NUM_COILS       = 16'h0002;
    localparam logic [15:0] CRC_INIT        = 16'hffff;
    localparam logic [15:0] CRC_POLY        = 16'ha001;
    localparam logic [3:0]  FRAME_LEN       = 4'h8;

    // ====================================================================
    // reset values
    localparam logic [15:0] RST_NODE        = 16'h0001;
    localparam logic [15:0] RST_RATE        = 16'h0003;
    localparam logic [15:0] RST_PROT        = 16'h0001;
    localparam logic [15:0] RST_ZERO        = 16'h0000;

    typedef enum logic {MBPM_IDLE, MBPM_SEND} mbpm_state_t;

endpackage : mbpm_pkg

// >>> testbench/mbpm_master.sv
// master model that sends request frames and gathers the replies
`timescale 1ns/1ns
`default_nettype none
module mbpm_master (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_valid,
    output logic            o_rx_valid,
    output logic      [7:0] o_rx_data,
    output logic            o_rx_end,
    output logic            o_tx_ready
);
    logic [7:0] rq [$];
    initial {o_rx_valid, o_rx_data, o_rx_end} = 10'h000;
    // take reply bytes; one stall at the fourth byte tests holding
    // the stall lasts one cycle, or a held count would block forever
    always @(posedge i_clk_sys)
        if (i_tx_valid && o_tx_ready)
            rq.push_back(i_tx_data);
    always @(negedge i_clk_sys)
        o_tx_ready <= rq.size() != 3 || !o_tx_ready;
    // one frame, crc lo then hi; bad spoils the crc on purpose
    task automatic req(input logic [47:0] f, input logic bad);
        logic [15:0] c;
        logic [7:0]  b [8];
        c = 16'hffff;
        for (int i = 0; i < 6; i++)
        begin
            b[i] = f[47-8*i -: 8];
            c = c ^ {8'h00, b[i]};
            for (int j = 0; j < 8; j++)
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        {b[7], b[6]} = c ^ {15'h0000, bad};
        rq.delete();
        for (int i = 0; i < 9; i++)
        begin
            @(negedge i_clk_sys);
            o_rx_valid = i < 8;
            o_rx_data = i < 8 ? b[i] : ~b[7]; // released line inverted
        end
        @(negedge i_clk_sys) o_rx_end = 1'b1;
        @(negedge i_clk_sys) o_rx_end = 1'b0;
        repeat (30) @(negedge i_clk_sys);
    endtask : req
endmodule : mbpm_master
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the modbus parameter and status map
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk, rst, rxv, rxe, rdy, txv, f_r, cs, ce, tl;
    logic [3:0]  seen = 4'h0;
    logic [7:0]  rxd, txd, node;
    logic [2:0]  rate;
    logic [1:0]  par, prot, outs, asg = 2'h2;
    logic [6:0]  cf = 7'h55;
    logic [15:0] pvo, drl, drh;
    int fails = 0, n_tests = 0;
    // status inputs share one pattern so few inputs stay tied
    mbpm_slave mbpm_slave_inst (.i_clk_sys(clk), .i_rst(rst),
        .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_end(rxe), .i_tx_ready(rdy),
        .i_range_lower_limit(16'hff9c), .i_range_upper_limit(16'h0064),
        .i_alarm_active(cf[1:0]), .i_hw_detect(cf[3:2]),
        .i_alarm_init_block(cf[5:4]), .i_temp_unit(cf[6]),
        .i_conv_fault(cf), .i_output_alarm_assigned(asg), .o_tx_data(txd),
        .o_tx_valid(txv), .o_tx_last(tl), .o_node_address(node),
        .o_bit_rate_select(rate), .o_parity_select(par), .o_pv_offset(pvo),
        .o_display_range_low(drl), .o_display_range_high(drh),
        .o_protection_level(prot), .o_cal_start_pulse(cs),
        .o_cal_end_pulse(ce), .o_factory_restore_pulse(f_r), .o_output(outs));
    mbpm_master mbpm_master_inst (.i_clk_sys(clk), .i_tx_data(txd),
        .i_tx_valid(txv), .o_rx_valid(rxv), .o_rx_data(rxd),
        .o_rx_end(rxe), .o_tx_ready(rdy));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
        seen <= seen | {tl & txv, ce, cs, f_r};
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // send a frame and compare the reply without its crc
    task automatic ask(input logic [47:0] f, input logic bad,
                       input logic [71:0] e, input int n);
        mbpm_master_inst.req(f, bad);
        chk(16'(mbpm_master_inst.rq.size()), 16'(n ? n + 2 : 0));
        for (int i = 0; i < n; i++)
            chk(16'(mbpm_master_inst.rq[i]), 16'(e[8*n-1-8*i -: 8]));
    endtask : ask
    task automatic t_reads;
        ask(48'h01_03_0064_0003, 0, 72'h01_03_06_0101_0220_0055, 9);
        ask(48'h01_02_0000_0001, 0, 72'h01_82_01, 3);
        ask(48'h01_03_0059_0001, 0, 72'h01_83_02, 3);
        ask(48'h01_03_0064_0000, 0, 72'h01_83_03, 3);
        ask(48'h01_06_0064_0001, 0, 72'h01_86_02, 3);
        ask(48'h01_05_0000_1234, 0, 72'h01_85_03, 3);
        ask(48'h01_03_0064_0001, 1, 72'h0, 0);
        ask(48'h00_03_0064_0001, 0, 72'h0, 0);
    endtask : t_reads
    task automatic t_coils;
        ask(48'h01_05_0000_ff00, 0, 72'h01_05_0000_ff00, 6);
        ask(48'h01_05_0001_ff00, 0, 72'h01_05_0001_ff00, 6);
        chk(16'(outs), 16'h0001);
        ask(48'h01_01_0000_0002, 0, 72'h01_01_01_01, 4);
    endtask : t_coils
    task automatic t_writes;
        ask(48'h01_06_0038_00c8, 0, 72'h01_06_0038_0064, 6);
        chk(pvo, 16'h0064);
        ask(48'h01_06_0039_ff38, 0, 72'h01_06_0039_ff38, 6);
        ask(48'h01_06_003a_0100, 0, 72'h01_06_003a_0100, 6);
        chk(drl, 16'hff38);
        chk(drh, 16'h0100);
        ask(48'h01_06_0050_0011, 0, 72'h01_06_0050_0011, 6);
        ask(48'h01_06_0051_0022, 0, 72'h01_06_0051_0022, 6);
        ask(48'h01_06_0052_0005, 0, 72'h01_06_0052_0001, 6);
        chk(16'(seen), 16'h000f);
        ask(48'h00_06_0045_0002, 0, 72'h0, 0);
        chk(16'(par), 16'h0002);
        ask(48'h01_06_0043_012c, 0, 72'h01_06_0043_00f7, 6);
        chk(16'(node), 16'h00f7);
        ask(48'hf7_06_0044_0009, 0, 72'hf7_06_0044_0007, 6);
        chk(16'(rate), 16'h0007);
    endtask : t_writes
    task automatic give_verdict;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        rst = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk({node, 1'b0, rate, par, prot}, 16'h0131);
        t_reads();
        t_coils();
        t_writes();
        give_verdict();
    end
    // about 820 cycles are needed, so this leaves wide margin
    initial
    begin
        repeat (3000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
